// ===== design/mbh_cfg.svh
`ifndef MBH_CFG_SVH
`define MBH_CFG_SVH

// Core clock rate and bus pulse width
`define MBH_CLK_MHZ 200
`define MBH_PULSE_NS 100
// Least pulse width, rounded up to whole cycles
`define MBH_PULSE_CYC ((`MBH_PULSE_NS * `MBH_CLK_MHZ + 999) / 1000)

// Faulty request recovery wait
`define MBH_TIMEOUT_US 100
`define MBH_TIMEOUT_CYC (`MBH_TIMEOUT_US * `MBH_CLK_MHZ)

// Bus geometry
`define MBH_ADDR_W 18
`define MBH_DATA_W 36
`define MBH_WORD_W (`MBH_DATA_W + 1)
`define MBH_WORD_BITS 14
// Bit 21 sits at this index of the 18-bit address, bit 35 at zero
`define MBH_BIT21_IDX 14

// Reset values
`define MBH_CNT_RST 5'h00
`define MBH_TMO_RST 15'h0000

`endif

// ===== design/mbh_pkg.sv
`include "mbh_cfg.svh"

package mbh_pkg;

  // Cycle sequencer states
  typedef enum logic [2:0] {
    mbh_idle    = 3'h0,
    mbh_ack     = 3'h1,
    mbh_rd_data = 3'h2,
    mbh_rd_done = 3'h3,
    mbh_wr_wait = 3'h4
  } mbh_state_t;

  // Whole state of the memory-side handshake
  typedef struct packed {
    mbh_state_t state;
    logic [4:0] pulse_cnt;
    logic [14:0] tmo_cnt;
    logic [`MBH_ADDR_W-1:0] word_addr;
    logic rd_flag;
    logic wr_flag;
    logic [`MBH_WORD_W-1:0] rdata;
    logic [`MBH_WORD_W-1:0] catch_word;
    logic wd_prev;
    logic ack;
    logic skip;
    logic rdone;
    logic drive;
  } mbh_regs_t;

endpackage

// ===== design/mbh_memory_port.sv
`timescale 1ns/10ps
`include "mbh_cfg.svh"

// Function
// - Select on address match, request, ready, no fast-store.
// - High true/complement pairs valid only during request.
// - Non-select address bits all address words uniquely.
// - Address capture only while module selected.
// - Address and request lines active when asserted.
// - Decode read, write, read-modify-write; neither zeros word.
// - Request type latched like address, only when selected.
// - Every pulse lasts 100 ns.
// - Pulses only on the port in cycle.
// - One acknowledge per accepted request, never otherwise.
// - No-parity module sends skip-parity with acknowledge.
// - Read done after data, read cycles only.
// - Missing write done stalls until cleared.
// - Maintenance switch blocks cycle request reception.
// - Pulse data catch register cleared before data.
// - Restart after 100 us on faulty request, switchable.
module mbh_memory_port #(
  parameter int WORD_BITS = `MBH_WORD_BITS,
  parameter bit HAS_PARITY = 1'b1,
  parameter int PULSE_CYC = `MBH_PULSE_CYC,
  parameter int TIMEOUT_CYC = `MBH_TIMEOUT_CYC
) (
  input wire logic clk_in, // Core clock
  input wire logic rst_in, // Sync reset, active high
  input wire logic cycle_request_in, // Cycle request level
  input wire logic [3:0] addr_hi_true_in, // Bits 18..21 true copies
  input wire logic [3:0] addr_hi_comp_in, // Bits 18..21 complements
  input wire logic [13:0] addr_lo_in, // Bits 22..35
  input wire logic read_request_in, // Read request level
  input wire logic write_request_in, // Write request level
  input wire logic fast_store_select_in, // Fast store select, true
  input wire logic write_done_pulse_in, // Write done pulse
  input wire logic [`MBH_DATA_W-1:0] bus_data_line_in, // Data pulses
  input wire logic parity_in, // Parity pulse
  input wire logic [`MBH_ADDR_W-WORD_BITS-1:0] module_base_in, // Switches
  input wire logic interleave_in, // Odd/even interleave on
  input wire logic maint_disable_in, // Maintenance request block
  input wire logic recovery_enable_in, // Faulty request restart on
  output logic address_ack_out, // Address acknowledge pulse
  output logic skip_parity_indication_out, // Skip parity pulse
  output logic read_done_pulse_out, // Read done pulse
  output logic [`MBH_DATA_W-1:0] bus_data_line_out, // Data pulses out
  output logic bus_data_line_oe_out, // Data drive enable
  output logic parity_out, // Parity pulse out
  output logic parity_oe_out // Parity drive enable
);

  localparam int SEL_BITS = `MBH_ADDR_W - WORD_BITS;
  localparam int DEPTH = 1 << WORD_BITS;

  // Refuse geometry and counts the counters cannot hold
  if (WORD_BITS < 1 || SEL_BITS < 1) begin : g_bad_words
    $error("word address width out of range");
  end
  if (PULSE_CYC < 1 || PULSE_CYC > 31) begin : g_bad_pulse
    $error("pulse length does not fit counter");
  end
  if (TIMEOUT_CYC < 1 || TIMEOUT_CYC > 32767) begin : g_bad_tmo
    $error("timeout does not fit counter");
  end

  mbh_pkg::mbh_regs_t st_q;
  mbh_pkg::mbh_regs_t st_d;
  logic [`MBH_WORD_W-1:0] mem_q [DEPTH];
  logic [`MBH_ADDR_W-1:0] addr_full;
  logic [`MBH_ADDR_W-1:0] addr_eff;
  logic hi_valid;
  logic selected;
  logic wd_edge;
  logic mem_we;
  logic [`MBH_WORD_W-1:0] mem_wdata;
  logic [`MBH_WORD_W-1:0] mem_rdata;
  logic [`MBH_WORD_W-1:0] catch_in;

  // Address assembly; interleave swaps bits 21 and 35
  assign addr_full = {addr_hi_true_in, addr_lo_in};
  assign addr_eff = interleave_in ?
    {addr_full[17:15], addr_full[0], addr_full[13:1],
     addr_full[`MBH_BIT21_IDX]} : addr_full;

  // High pairs trusted only while request is active
  assign hi_valid = cycle_request_in &
    (&(addr_hi_true_in ^ addr_hi_comp_in));

  // Module selection decode with ready and switch terms
  assign selected = hi_valid & ~maint_disable_in &
    ~fast_store_select_in & (st_q.state == mbh_pkg::mbh_idle) &
    (addr_eff[`MBH_ADDR_W-1:WORD_BITS] == module_base_in);

  // Leading edge of the write done pulse
  assign wd_edge = write_done_pulse_in & ~st_q.wd_prev;

  // Incoming pulses, parity ignored without storage
  assign catch_in = {bus_data_line_in, parity_in & HAS_PARITY};

  assign mem_rdata = mem_q[st_q.word_addr[WORD_BITS-1:0]];

  // Cycle sequencer
  always_comb begin
    st_d = st_q;
    st_d.wd_prev = write_done_pulse_in;
    st_d.ack = 1'b0;
    st_d.skip = 1'b0;
    st_d.rdone = 1'b0;
    st_d.drive = 1'b0;
    mem_we = 1'b0;
    mem_wdata = st_q.catch_word;
    unique case (st_q.state)
      mbh_pkg::mbh_idle: begin
        if (selected) begin
          st_d.state = mbh_pkg::mbh_ack;
          st_d.word_addr = addr_eff;
          st_d.rd_flag = read_request_in;
          st_d.wr_flag = write_request_in;
          st_d.ack = 1'b1;
          st_d.skip = ~HAS_PARITY;
          st_d.pulse_cnt = `MBH_CNT_RST;
        end
      end
      mbh_pkg::mbh_ack: begin
        if (st_q.pulse_cnt == 5'(PULSE_CYC - 1)) begin
          st_d.pulse_cnt = `MBH_CNT_RST;
          if (st_q.rd_flag) begin
            st_d.state = mbh_pkg::mbh_rd_data;
            st_d.rdata = mem_rdata;
            st_d.drive = 1'b1;
          end else if (st_q.wr_flag) begin
            st_d.state = mbh_pkg::mbh_wr_wait;
            st_d.catch_word = '0;
            st_d.tmo_cnt = `MBH_TMO_RST;
          end else begin
            // Undefined request type clears the word
            mem_we = 1'b1;
            mem_wdata = '0;
            st_d.state = mbh_pkg::mbh_idle;
          end
        end else begin
          st_d.pulse_cnt = st_q.pulse_cnt + 5'h01;
          st_d.ack = 1'b1;
          st_d.skip = st_q.skip;
        end
      end
      mbh_pkg::mbh_rd_data: begin
        // Data and parity pulses on this port only
        if (st_q.pulse_cnt == 5'(PULSE_CYC - 1)) begin
          st_d.pulse_cnt = `MBH_CNT_RST;
          st_d.state = mbh_pkg::mbh_rd_done;
          st_d.rdone = 1'b1;
        end else begin
          st_d.pulse_cnt = st_q.pulse_cnt + 5'h01;
          st_d.drive = 1'b1;
        end
      end
      mbh_pkg::mbh_rd_done: begin
        if (st_q.pulse_cnt == 5'(PULSE_CYC - 1)) begin
          st_d.pulse_cnt = `MBH_CNT_RST;
          if (st_q.wr_flag) begin
            st_d.state = mbh_pkg::mbh_wr_wait;
            st_d.catch_word = '0;
            st_d.tmo_cnt = `MBH_TMO_RST;
          end else begin
            st_d.state = mbh_pkg::mbh_idle;
          end
        end else begin
          st_d.pulse_cnt = st_q.pulse_cnt + 5'h01;
          st_d.rdone = 1'b1;
        end
      end
      mbh_pkg::mbh_wr_wait: begin
        // Catch pulses only during our own write phase
        st_d.catch_word = st_q.catch_word | catch_in;
        if (wd_edge) begin
          mem_we = 1'b1;
          mem_wdata = st_q.catch_word | catch_in;
          st_d.state = mbh_pkg::mbh_idle;
        end else if (st_q.tmo_cnt == 15'(TIMEOUT_CYC - 1)) begin
          if (recovery_enable_in) begin
            st_d.state = mbh_pkg::mbh_idle;
          end
        end else begin
          st_d.tmo_cnt = st_q.tmo_cnt + 15'h0001;
        end
      end
      default: begin
        st_d.state = mbh_pkg::mbh_idle;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Word storage
  always_ff @(posedge clk_in) begin
    if (mem_we) begin
      mem_q[st_q.word_addr[WORD_BITS-1:0]] <= mem_wdata;
    end
  end

  // Outputs straight from the state register
  assign address_ack_out = st_q.ack;
  assign skip_parity_indication_out = st_q.skip;
  assign read_done_pulse_out = st_q.rdone;
  assign bus_data_line_out = st_q.rdata[`MBH_WORD_W-1:1];
  assign bus_data_line_oe_out = st_q.drive;
  assign parity_out = st_q.rdata[0] & HAS_PARITY;
  assign parity_oe_out = st_q.drive & HAS_PARITY;

endmodule // mbh_memory_port

// ===== bench/mbh_chk_sva.sv
`timescale 1ns/10ps
module mbh_chk #(parameter int PC = 3, parameter bit HP = 1'b1) (
  input wire logic clk_in, // Clock
  input wire logic rst_in, // Reset
  input wire logic cycle_request_in, // Request
  input wire logic address_ack_out, // Ack
  input wire logic skip_parity_indication_out, // Skip
  input wire logic read_done_pulse_out, // Read done
  input wire logic bus_data_line_oe_out, // Data drive
  input wire logic parity_oe_out // Parity drive
);
  // Pulse shapes and their order
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  ack_width_a: assert property ($rose(address_ack_out) |->
    ##PC $fell(address_ack_out)) else $error("ack width");
  ack_cause_a: assert property ($rose(address_ack_out) |->
    $past(cycle_request_in)) else $error("ack cause");
  data_after_ack_a: assert property ($rose(bus_data_line_oe_out) |->
    $past(address_ack_out) && !address_ack_out) else $error("data early");
  done_after_data_a: assert property ($rose(bus_data_line_oe_out) |->
    ##PC $rose(read_done_pulse_out)) else $error("done late");
  done_width_a: assert property ($rose(read_done_pulse_out) |->
    ##PC $fell(read_done_pulse_out)) else $error("done width");
  one_pulse_a: assert property (!(address_ack_out &&
    (bus_data_line_oe_out || read_done_pulse_out))) else $error("overlap");
  skip_par_a: assert property (skip_parity_indication_out ==
    (address_ack_out && !HP)) else $error("skip");
  par_oe_a: assert property (parity_oe_out ==
    (bus_data_line_oe_out && HP)) else $error("parity drive");
endmodule // mbh_chk

bind mbh_memory_port mbh_chk #(.PC(PULSE_CYC), .HP(HAS_PARITY)) u_chk (
  .clk_in(clk_in), .rst_in(rst_in), .cycle_request_in(cycle_request_in),
  .address_ack_out(address_ack_out), .parity_oe_out(parity_oe_out),
  .skip_parity_indication_out(skip_parity_indication_out),
  .read_done_pulse_out(read_done_pulse_out),
  .bus_data_line_oe_out(bus_data_line_oe_out));

// ===== bench/mbh_cpu.sv
`timescale 1ns/10ps
module mbh_cpu #(parameter int PC = 3) (
  input wire logic clk_in, // Clock
  input wire logic ack_in, // Ack
  input wire logic rdone_in, // Read done
  input wire logic skip_in, // Skip parity
  input wire logic [36:0] bus_in, // Data lines
  output logic req_out, // Request
  output logic [17:0] a_out, // Address
  output logic [3:0] comp_out, // Complements
  output logic rd_out, // Read request
  output logic wr_out, // Write request
  output logic wd_out, // Write done
  output logic [36:0] w_out // Data pulses
);
  // Complements honest only while requesting
  assign comp_out = req_out ? ~a_out[17:14] : a_out[17:14];
  // Lines rest idle; all outputs start low here
  initial {req_out, a_out, rd_out, wr_out, wd_out, w_out} = '0;
  task automatic tick;
    @(posedge clk_in) #1;
  endtask
  // Write done pulse
  task automatic done;
    wd_out = 1'h1;
    repeat (PC) tick;
    wd_out = 1'h0;
  endtask
  // One cycle; lines settle before the request rises
  task automatic cyc(input logic [17:0] a, input logic r, w, dn,
    input logic [36:0] d, output logic [36:0] q, output logic ok);
    logic skipped;
    {a_out, rd_out, wr_out, q} = {a, r, w, 37'h0};
    tick;
    req_out = 1'h1;
    // Scaled wait for a missing memory
    for (int n = 0; n < 99 && !ack_in; n++) tick;
    ok = ack_in;
    skipped = skip_in;
    req_out = 1'h0;
    for (int n = 0; n < 60 && r && ok && !rdone_in; n++) begin
      q = q | bus_in;
      tick;
    end
    if (r && ok) testbench.chk(rdone_in, 1'h1);
    // Parity bit of a module without parity is not trusted
    if (skipped) q[0] = 1'h0;
    for (int n = 0; n < 9 && (ack_in || rdone_in); n++) tick;
    testbench.chk(ack_in | rdone_in, 1'h0);
    if (w && ok) begin
      w_out = d;
      repeat (PC) tick;
      w_out = 37'h0;
      if (dn) done;
    end
  endtask
endmodule // mbh_cpu

// ===== bench/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic clk_in, rst_in, mt, fs, rc, ack, sk, rdn, oe, poe, par;
  logic req, rd, wr, wd, ok, il;
  logic [35:0] dout;
  logic [17:0] a;
  logic [3:0] cp;
  logic [36:0] w, bus, q;
  int mismatches, n_checks;
  localparam logic H = 1'h1, L = 1'h0;
  localparam logic [17:0] A1 = 18'h14003, A2 = 18'h17ffc;
  localparam logic [36:0] D1 = 37'h1a5a5a5a5b, D2 = 37'h05a5a5a5a4;
  // Wire level of the shared data lines
  assign bus = w | {dout & {36{oe}}, par & poe};
  mbh_memory_port #(.PULSE_CYC(3), .TIMEOUT_CYC(50)) uut (.clk_in(clk_in),
    .rst_in(rst_in), .cycle_request_in(req), .addr_hi_true_in(a[17:14]),
    .addr_hi_comp_in(cp), .addr_lo_in(a[13:0]), .read_request_in(rd),
    .write_request_in(wr), .fast_store_select_in(fs),
    .write_done_pulse_in(wd), .bus_data_line_in(bus[36:1]),
    .parity_in(bus[0]), .module_base_in(4'h5), .interleave_in(il),
    .maint_disable_in(mt), .recovery_enable_in(rc), .address_ack_out(ack),
    .skip_parity_indication_out(sk), .read_done_pulse_out(rdn),
    .bus_data_line_out(dout), .bus_data_line_oe_out(oe), .parity_out(par),
    .parity_oe_out(poe));
  mbh_cpu #(.PC(3)) cpu (.clk_in(clk_in), .ack_in(ack), .rdone_in(rdn),
    .skip_in(sk),
    .bus_in(bus), .req_out(req), .a_out(a), .comp_out(cp), .rd_out(rd),
    .wr_out(wr), .wd_out(wd), .w_out(w));
  task automatic chk(input logic [36:0] s, e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Two words written, both read back
  task automatic t_write_read;
    cpu.cyc(A1, L, H, H, D1, q, ok);
    chk(ok, H);
    cpu.cyc(A2, L, H, H, D2, q, ok);
    cpu.cyc(A1, H, L, H, 37'h0, q, ok);
    chk(q, D1);
    cpu.cyc(A2, H, L, H, 37'h0, q, ok);
    chk(q, D2);
  endtask
  // Missing write done: restart, then stall
  task automatic t_fault;
    rc = H;
    cpu.cyc(A1, L, H, L, D2, q, ok);
    cpu.cyc(A1, H, L, H, 37'h0, q, ok);
    chk(q, D1);
    rc = L;
    cpu.cyc(A2, L, H, L, D1, q, ok);
    cpu.cyc(A1, H, L, H, 37'h0, q, ok);
    chk(ok, L);
    cpu.done;
    cpu.cyc(A2, H, L, H, 37'h0, q, ok);
    chk(q, D1);
  endtask
  // Read-modify-write, then an empty request
  task automatic t_rmw_none;
    cpu.cyc(A1, H, H, H, D2, q, ok);
    chk(q, D1);
    cpu.cyc(A1, H, L, H, 37'h0, q, ok);
    chk(q, D2);
    cpu.cyc(A2, L, L, H, 37'h0, q, ok);
    cpu.cyc(A2, H, L, H, 37'h0, q, ok);
    chk(q, 37'h0);
  endtask
  // Odd/even interleave: bit 35 selects, bit 21 addresses
  task automatic t_interleave;
    il = H;
    cpu.cyc(18'h14004, H, L, H, 37'h0, q, ok);
    chk(ok, L);
    cpu.cyc(18'h10005, L, H, H, D1, q, ok);
    chk(ok, H);
    il = L;
    cpu.cyc(18'h14004, H, L, H, 37'h0, q, ok);
    chk(q, D1);
  endtask
  // Requests the module must ignore
  task automatic t_refuse;
    for (int i = 0; i < 3; i++) begin
      mt = (i == 1);
      fs = (i == 2);
      cpu.cyc(i == 0 ? 18'h24003 : A1, H, L, H, 37'h0, q, ok);
      chk(ok, L);
    end
    mt = L;
    fs = L;
  endtask
  initial begin
    clk_in = L;
    forever #2.5 clk_in = ~clk_in;
  end
  // Reset, then each scenario in turn
  initial begin
    // Fast store select held false, as are the other switches
    {rst_in, mt, fs, rc, il} = 5'h10;
    mismatches = 0;
    n_checks = 0;
    repeat (8) @(posedge clk_in);
    #1 rst_in = L;
    chk({ack, sk, rdn, oe, poe}, 37'h0);
    t_write_read;
    t_fault;
    t_rmw_none;
    t_interleave;
    t_refuse;
    summarize;
  end
endmodule // testbench
